// ---- rtl/mop_map.svh ----
`ifndef MOP_MAP_SVH
`define MOP_MAP_SVH
// Register byte offsets
`define MOP_OFS_EMG_CTRL      4'h0
`define MOP_OFS_OVL_CTRL      4'h4
`define MOP_OFS_EMG_KEY       4'h8
`define MOP_OFS_PHASE_IN      4'hc
// Field positions, emergency_control
`define MOP_EC_ENABLE         0
`define MOP_EC_RETURN         1
`define MOP_EC_STATE          2
`define MOP_EC_CNT_LO         4
`define MOP_EC_CNT_HI         7
// Field positions, overload_control
`define MOP_OC_ENABLE         0
`define MOP_OC_CNTSTOP        1
`define MOP_OC_SEL_LO         2
`define MOP_OC_SEL_HI         3
`define MOP_OC_STATE          4
`define MOP_OC_RET_TMR        5
`define MOP_OC_RET_PWM        6
`define MOP_OC_RET_MAN        7
// Reset values
`define MOP_EC_RESET          8'h01
`define MOP_OC_RESET          8'h00
// Disable keys
`define MOP_KEY_FIRST         8'h5a
`define MOP_KEY_SECOND        8'ha5
// Timing
`define MOP_CLK_NS            8
`define MOP_SAMPLE_NS         200
`define MOP_SAMPLE_CYC        ((`MOP_SAMPLE_NS + `MOP_CLK_NS - 1) / `MOP_CLK_NS)
`endif

// ---- rtl/mop_pkg.sv ----
package mop_pkg;
    typedef enum logic [1:0] {
        MOP_CUT_NONE  = 2'h0,
        MOP_CUT_ALL   = 2'h1,
        MOP_CUT_PWM   = 2'h2,
        MOP_CUT_GROUP = 2'h3
    } mop_cut_t;
    typedef enum logic [2:0] {
        MOP_KEY_IDLE = 3'h1,
        MOP_KEY_HALF = 3'h2,
        MOP_KEY_OPEN = 3'h4
    } mop_key_state_t;
    // Six phase outputs: upper u,v,w then lower x,y,z
    typedef struct packed {
        logic [2:0] upper;
        logic [2:0] lower;
    } mop_phase_t;
    typedef struct packed {
        mop_phase_t level;
        mop_phase_t oe;
    } mop_drive_t;
endpackage

// ---- rtl/mop_protect.sv ----
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "mop_map.svh"
module mop_protect
    import mop_pkg::*;
#(
    parameter int SAMPLE_CYC = `MOP_SAMPLE_CYC
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire mop_phase_t  i_phase_level,
    input  wire mop_phase_t  i_phase_is_pwm,
    input  wire mop_phase_t  i_phase_active_high,
    input  wire logic        i_pwm_sync,
    input  wire logic        i_timer1_sync,
    input  wire logic        i_emergency_stop_input,
    input  wire logic        i_overload_sense_input,
    output mop_drive_t       o_phase_drive,
    output logic             o_emergency_irq,
    output logic             o_overload_irq,
    output logic             o_pwm_counter_stop
);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
logic [2:0] emg_sync_q;
logic [2:0] ovl_sync_q;
logic       emg_level_q;
logic       ovl_level_q;

always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        emg_sync_q  <= 3'h7;
        ovl_sync_q  <= 3'h7;
        emg_level_q <= 1'b1;
        ovl_level_q <= 1'b1;
    end else begin
        emg_sync_q <= {emg_sync_q[1:0], i_emergency_stop_input};
        ovl_sync_q <= {ovl_sync_q[1:0], i_overload_sense_input};
        if (emg_sync_q[1] == emg_sync_q[2]) begin
            emg_level_q <= emg_sync_q[2];
        end
        if (ovl_sync_q[1] == ovl_sync_q[2]) begin
            ovl_level_q <= ovl_sync_q[2];
        end
    end
end

function automatic logic two_or_more(input logic [2:0] v);
    two_or_more = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
endfunction

// ----------------------------------------
// Bus decode
// ----------------------------------------
logic        wait_q;
logic [31:0] rdata_q;
logic        acc;
logic        wr_go;
logic        wr_ec;
logic        wr_oc;
logic        wr_key;

assign acc    = (i_avs_read | i_avs_write) & wait_q;
assign wr_go  = i_avs_write & ~wait_q & i_avs_byteenable[0];
assign wr_ec  = wr_go & (i_avs_address == `MOP_OFS_EMG_CTRL);
assign wr_oc  = wr_go & (i_avs_address == `MOP_OFS_OVL_CTRL);
assign wr_key = wr_go & (i_avs_address == `MOP_OFS_EMG_KEY);

// ----------------------------------------
// Key sequence
// ----------------------------------------
mop_key_state_t key_q;

always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        key_q <= MOP_KEY_IDLE;
    end else if (wr_key) begin
        case (key_q)
            MOP_KEY_IDLE: begin
                key_q <= (i_avs_writedata[7:0] == `MOP_KEY_FIRST) ? MOP_KEY_HALF : MOP_KEY_IDLE;
            end
            MOP_KEY_HALF: begin
                key_q <= (i_avs_writedata[7:0] == `MOP_KEY_SECOND) ? MOP_KEY_OPEN :
                         (i_avs_writedata[7:0] == `MOP_KEY_FIRST) ? MOP_KEY_HALF : MOP_KEY_IDLE;
            end
            MOP_KEY_OPEN: begin
                key_q <= (i_avs_writedata[7:0] == `MOP_KEY_FIRST) ? MOP_KEY_HALF : MOP_KEY_IDLE;
            end
            default: begin
                key_q <= MOP_KEY_IDLE;
            end
        endcase
    end else if (wr_ec) begin
        key_q <= MOP_KEY_IDLE;
    end
end

// ----------------------------------------
// Emergency path
// ----------------------------------------
logic       emg_en_q;
logic       emg_state_q;
logic       emg_prev_q;
logic       emg_fall;
logic [3:0] cnt_sel_q;

assign emg_fall = emg_prev_q & ~emg_level_q;

always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        emg_prev_q <= 1'b1;
    end else begin
        emg_prev_q <= emg_level_q;
    end
end

// ----------------------------------------
// Emergency enable
// ----------------------------------------
always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        emg_en_q <= 1'b1;
    end else if (wr_ec) begin
        if (i_avs_writedata[`MOP_EC_ENABLE]) begin
            emg_en_q <= 1'b1;
        end else if (key_q == MOP_KEY_OPEN) begin
            emg_en_q <= 1'b0;
        end
    end
end

// ----------------------------------------
// Emergency state
// ----------------------------------------
always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        emg_state_q     <= 1'b0;
        o_emergency_irq <= 1'b0;
    end else begin
        o_emergency_irq <= emg_en_q & emg_fall;
        if (emg_en_q & emg_fall) begin
            emg_state_q <= 1'b1;
        end else if (wr_ec & i_avs_writedata[`MOP_EC_RETURN] & emg_level_q) begin
            emg_state_q <= 1'b0;
        end
    end
end

// ----------------------------------------
// Overload sampling
// ----------------------------------------
logic [7:0] tick_q;
logic [3:0] low_cnt_q;
logic [3:0] need;
logic       ovl_detect;

always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        cnt_sel_q <= 4'h0;
    end else if (wr_ec) begin
        cnt_sel_q <= i_avs_writedata[`MOP_EC_CNT_HI:`MOP_EC_CNT_LO];
    end
end

assign need = (cnt_sel_q == 4'h0) ? 4'h1 : cnt_sel_q;

always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        tick_q    <= 8'h00;
        low_cnt_q <= 4'h0;
    end else begin
        tick_q <= (tick_q == 8'(SAMPLE_CYC - 1)) ? 8'h00 : tick_q + 8'h01;
        if (tick_q == 8'(SAMPLE_CYC - 1)) begin
            if (ovl_level_q) begin
                low_cnt_q <= 4'h0;
            end else if (low_cnt_q != 4'hf) begin
                low_cnt_q <= low_cnt_q + 4'h1;
            end
        end
    end
end

assign ovl_detect = (low_cnt_q >= need) & ~ovl_level_q;

// ----------------------------------------
// Overload state
// ----------------------------------------
logic     ovl_en_q;
logic     ovl_state_q;
logic     cnt_stop_q;
logic     ret_pwm_q;
logic     ret_tmr_q;
mop_cut_t cut_q;
logic     ovl_ret;

assign ovl_ret = ovl_level_q & ((wr_oc & i_avs_writedata[`MOP_OC_RET_MAN])
                 | (ret_pwm_q & i_pwm_sync)
                 | (ret_tmr_q & i_timer1_sync));

always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        ovl_en_q   <= 1'b0;
        cnt_stop_q <= 1'b0;
        ret_pwm_q  <= 1'b0;
        ret_tmr_q  <= 1'b0;
        cut_q      <= MOP_CUT_NONE;
    end else if (wr_oc) begin
        ovl_en_q   <= i_avs_writedata[`MOP_OC_ENABLE];
        cnt_stop_q <= i_avs_writedata[`MOP_OC_CNTSTOP];
        ret_pwm_q  <= i_avs_writedata[`MOP_OC_RET_PWM];
        ret_tmr_q  <= i_avs_writedata[`MOP_OC_RET_TMR];
        cut_q      <= mop_cut_t'(i_avs_writedata[`MOP_OC_SEL_HI:`MOP_OC_SEL_LO]);
    end
end

always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        ovl_state_q    <= 1'b0;
        o_overload_irq <= 1'b0;
    end else begin
        o_overload_irq <= ovl_en_q & ~ovl_state_q & ovl_detect;
        if (~ovl_en_q) begin
            ovl_state_q <= 1'b0;
        end else if (~ovl_state_q & ovl_detect) begin
            ovl_state_q <= 1'b1;
        end else if (ovl_state_q & ovl_ret) begin
            ovl_state_q <= 1'b0;
        end
    end
end

// ----------------------------------------
// Phase output gating
// ----------------------------------------
mop_phase_t snap_q;
mop_phase_t on_now;
mop_phase_t cut_mask;
mop_phase_t force_on;
mop_phase_t lvl;

function automatic mop_phase_t to_level(input mop_phase_t on, input mop_phase_t ah);
    to_level = ~(on ^ ah);
endfunction

assign on_now = ~(i_phase_level ^ i_phase_active_high);

always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        snap_q <= '0;
    end else if (~ovl_state_q) begin
        snap_q <= on_now;
    end
end

always_comb begin
    cut_mask = '0;
    force_on = '0;
    case (cut_q)
        MOP_CUT_NONE: begin
            cut_mask = '0;
        end
        MOP_CUT_ALL: begin
            cut_mask = '1;
        end
        MOP_CUT_PWM: begin
            cut_mask = i_phase_is_pwm;
        end
        MOP_CUT_GROUP: begin
            if (two_or_more(snap_q.upper)) begin
                force_on.upper = 3'h7;
                cut_mask       = '1;
            end else if (two_or_more(snap_q.lower)) begin
                force_on.lower = 3'h7;
                cut_mask       = '1;
            end
        end
        default: begin
            cut_mask = '0;
        end
    endcase
    if (ovl_state_q) begin
        lvl = (i_phase_level & ~cut_mask) | (to_level(force_on, i_phase_active_high) & cut_mask);
    end else begin
        lvl = i_phase_level;
    end
end

always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        o_phase_drive <= '0;
    end else begin
        o_phase_drive.level <= lvl;
        o_phase_drive.oe    <= (emg_state_q | (emg_en_q & emg_fall)) ? '0 : '1;
    end
end

// ----------------------------------------
// Counter stop
// ----------------------------------------
always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        o_pwm_counter_stop <= 1'b0;
    end else begin
        o_pwm_counter_stop <= ovl_state_q & cnt_stop_q;
    end
end

// ----------------------------------------
// Bus answer
// ----------------------------------------
always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        wait_q <= 1'b1;
    end else begin
        wait_q <= ~acc;
    end
end

// ----------------------------------------
// Read data
// ----------------------------------------
always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
        rdata_q <= 32'h0000_0000;
    end else if (acc & i_avs_read) begin
        case (i_avs_address)
            `MOP_OFS_EMG_CTRL: begin
                rdata_q <= {24'h0, cnt_sel_q, 1'b0, emg_state_q, 1'b0, emg_en_q};
            end
            `MOP_OFS_OVL_CTRL: begin
                rdata_q <= {24'h0, 1'b0, ret_pwm_q, ret_tmr_q, ovl_state_q, cut_q, cnt_stop_q, ovl_en_q};
            end
            default: begin
                rdata_q <= 32'h0000_0000;
            end
        endcase
    end
end

assign o_avs_readdata    = rdata_q;
assign o_avs_waitrequest = wait_q;

endmodule // mop_protect

// ---- tb/mop_protect_checker.sv ----
`timescale 1ns/100ps
module mop_protect_checker
    import mop_pkg::*;
(
    input wire logic       i_core_clk,
    input wire logic       i_reset,
    input wire logic       i_emergency_stop_input,
    input wire logic       i_overload_sense_input,
    input wire mop_drive_t o_phase_drive,
    input wire logic       o_emergency_irq,
    input wire logic       o_overload_irq,
    input wire logic       o_pwm_counter_stop
);
    // ----------------
    // Properties
    // ----------------
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    emg_oe_off_a: assert property (o_emergency_irq |-> ##[0:1] (o_phase_drive.oe == 6'h00))
        else $error("oe on at stop");
    emg_pulse_a: assert property (o_emergency_irq |=> !o_emergency_irq)
        else $error("emg irq long");
    emg_cause_a: assert property (o_emergency_irq |-> !$past(i_emergency_stop_input, 3))
        else $error("emg irq no cause");
    ovl_pulse_a: assert property (o_overload_irq |=> !o_overload_irq)
        else $error("ovl irq long");
    ovl_cause_a: assert property (o_overload_irq |-> !$past(i_overload_sense_input, 4))
        else $error("ovl irq no cause");
    stop_start_a: assert property ($rose(o_pwm_counter_stop) |-> !$past(i_overload_sense_input, 4))
        else $error("stop no cause");
    stop_end_a: assert property ($fell(o_pwm_counter_stop) |-> $past(i_overload_sense_input, 4))
        else $error("return while low");
    oe_back_a: assert property ($rose(o_phase_drive.oe == 6'h3f) |-> $past(i_emergency_stop_input, 4))
        else $error("oe back while low");
    cover property (o_emergency_irq);
    cover property (o_overload_irq ##[0:2] o_pwm_counter_stop);
    cover property ($fell(o_pwm_counter_stop));
endmodule // mop_protect_checker

bind mop_protect mop_protect_checker mop_protect_checker_inst (
    .i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_emergency_stop_input(i_emergency_stop_input), .i_overload_sense_input(i_overload_sense_input),
    .o_phase_drive(o_phase_drive), .o_emergency_irq(o_emergency_irq),
    .o_overload_irq(o_overload_irq), .o_pwm_counter_stop(o_pwm_counter_stop));

// ---- tb/mop_stage_model.sv ----
`timescale 1ns/100ps
// ----------------
// Power stage sync sources
// ----------------
module mop_stage_model (
    input  wire logic i_core_clk,
    input  wire logic i_reset,
    input  wire logic i_counter_stop,
    output logic      o_pwm_sync,
    output logic      o_timer1_sync
);
    logic [4:0] pwm_q;
    logic [5:0] tmr_q;
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            pwm_q <= 5'h00;
            tmr_q <= 6'h00;
        end else begin
            pwm_q <= i_counter_stop ? pwm_q : pwm_q + 5'h01;
            tmr_q <= tmr_q + 6'h01;
        end
    end
    assign o_pwm_sync    = (pwm_q == 5'h1f) && !i_counter_stop;
    assign o_timer1_sync = (tmr_q == 6'h3f);
endmodule // mop_stage_model

// ---- tb/tb_mop_protect.sv ----
`timescale 1ns/100ps
module tb_mop_protect
    import mop_pkg::*;
;
    typedef struct packed {
        logic [3:0] a;
        logic [7:0] w;
        logic [7:0] e;
    } mop_row_t;
    mop_row_t    rows [4] = '{'{4'h0, 8'h30, 8'h31}, '{4'h4, 8'hee, 8'h6e},
                              '{4'h8, 8'h00, 8'h00}, '{4'hc, 8'hff, 8'h00}};
    logic [7:0]  cfg [4]  = '{8'h03, 8'h45, 8'h2b, 8'h0f};
    logic [5:0]  cut [4]  = '{6'h1c, 6'h00, 6'h14, 6'h38};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  adr = 4'h0;
    logic        rd  = 1'b0;
    logic        wr  = 1'b0;
    logic [31:0] wd  = 32'h0;
    logic [3:0]  be  = 4'h1;
    logic        emergency_stop_input = 1'b1;
    logic        ovl = 1'b1;
    mop_phase_t  lvl = 6'h1c;
    logic [31:0] rdat;
    logic        wreq, eirq, oirq, stop, psync, tsync;
    mop_drive_t  drv;
    logic [11:0] ecnt = 12'h0;
    logic [11:0] ocnt = 12'h0;
    logic [11:0] rq;
    int          mismatches = 0;
    int          num_checks = 0;

    mop_protect #(.SAMPLE_CYC(2)) mop_protect_inst (
        .i_core_clk(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .i_phase_level(lvl), .i_phase_is_pwm(6'h09), .i_phase_active_high(6'h3f),
        .i_pwm_sync(psync), .i_timer1_sync(tsync), .i_emergency_stop_input(emergency_stop_input),
        .i_overload_sense_input(ovl), .o_phase_drive(drv), .o_emergency_irq(eirq),
        .o_overload_irq(oirq), .o_pwm_counter_stop(stop));
    mop_stage_model mop_stage_model_inst (.i_core_clk(clk), .i_reset(rst), .i_counter_stop(stop),
        .o_pwm_sync(psync), .o_timer1_sync(tsync));

    always #4 clk = ~clk;
    always @(posedge clk) begin
        ecnt <= ecnt + 12'(eirq === 1'b1);
        ocnt <= ocnt + 12'(oirq === 1'b1);
    end

    // ----------------
    // Tasks
    // ----------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        rd  <= !w;
        wr  <= w;
        adr <= a;
        wd  <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        rq = {4'h0, rdat[7:0]};
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, rq, {4'h0, e});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        cyc(20000);
        mismatches++;
        end_of_test();
    end

    // ----------------
    // Sequence
    // ----------------
    initial begin
        cyc(10);
        rst <= 1'b0;
        rdc("emg_ctrl", 4'h0, 8'h01);
        rdc("ovl_ctrl", 4'h4, 8'h00);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].w);
            rdc("row", rows[i].a, rows[i].e);
        end
        be <= 4'h0;
        bus(1'b1, 4'h4, 8'h01);
        be <= 4'h1;
        rdc("no_lane", 4'h4, 8'h6e);
        bus(1'b1, 4'h8, 8'h5a);
        bus(1'b1, 4'h8, 8'ha5);
        bus(1'b1, 4'h0, 8'h40);
        rdc("emg_off", 4'h0, 8'h40);
        emergency_stop_input <= 1'b0;
        ovl <= 1'b0;
        cyc(30);
        chk("emg_irq", ecnt, 12'h0);
        chk("ovl_irq", ocnt, 12'h0);
        chk("drive", drv, {lvl, 6'h3f});
        emergency_stop_input <= 1'b1;
        ovl <= 1'b1;
        cyc(10);
        bus(1'b1, 4'h0, 8'h41);
        emergency_stop_input <= 1'b0;
        cyc(12);
        chk("emg_irq", ecnt, 12'h1);
        chk("emg_oe", 12'(drv.oe), 12'h0);
        rdc("emg_st", 4'h0, 8'h45);
        bus(1'b1, 4'h0, 8'h43);
        rdc("emg_st", 4'h0, 8'h45);
        emergency_stop_input <= 1'b1;
        cyc(8);
        bus(1'b1, 4'h0, 8'h43);
        rdc("emg_st", 4'h0, 8'h41);
        chk("drive", drv, {lvl, 6'h3f});
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 4'h4, cfg[m]);
            ovl <= 1'b0;
            cyc(4);
            ovl <= 1'b1;
            cyc(4);
            ovl <= 1'b0;
            cyc(4);
            ovl <= 1'b1;
            cyc(8);
            chk("early", ocnt, 12'(m));
            ovl <= 1'b0;
            cyc(30);
            chk("ovl_irq", ocnt, 12'(m + 1));
            chk("cut", drv, {cut[m], 6'h3f});
            chk("stop", 12'(stop), 12'(cfg[m][1]));
            rdc("ovl_st", 4'h4, cfg[m] | 8'h10);
            bus(1'b1, 4'h4, cfg[m] | 8'h80);
            cyc(70);
            rdc("ovl_held", 4'h4, cfg[m] | 8'h10);
            ovl <= 1'b1;
            cyc(8);
            if (cfg[m][6:5] == 2'b00) bus(1'b1, 4'h4, cfg[m] | 8'h80);
            cyc(70);
            rdc("ovl_ret", 4'h4, cfg[m]);
            chk("resume", drv, {lvl, 6'h3f});
        end
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        rdc("emg_ctrl", 4'h0, 8'h01);
        end_of_test();
    end
endmodule // tb_mop_protect
